// File: logic/lpl_pkg.sv
// constants for the serial packet loader and grayscale pwm sequencer
// Operation
// R1 - select flag set: shift clock drives pwm
// R2 - output disable flag is one after reset
// R3 - 224-bit packets, msb first, six-bit command
// R4 - latch only when command equals 25h
// R5 - controller sends farthest packet first, gapless
// R6 - controller idles clock eight last periods
// R7 - idle detected: latch pulse copies 218 bits
// R8 - controller writes repeat 0, reset 1, disable 0
// R9 - timing reset at latch; no repeat without flag
// R10 - controller starts pwm 1.34us after latch
// R11 - first pwm clock lights nonzero channels
// R12 - display period is 65536 shift clocks
// R13 - controller repeats write, latch, pwm clocks
// R14 - idle interval scales, 666 ns to 2.74 ms
// R15 - long chain: 57344 clocks per write
// R16 - long chain: 8192 pwm-only clocks after latch
// R17 - pwm keeps counting while packets shift in
// R18 - long chain: controller repeats whole cycle
// R19 - packet fields: function, brightness, grayscale
// R20 - controller rewrites all packets on change
// R21 - shift register sampled on rise, feeds next
package lpl_pkg;

  // -------------------------------------------------------------------
  // packet layout
  // -------------------------------------------------------------------
  localparam int          PKT_W       = 224;
  localparam int          LATCH_W     = 218;
  localparam int          CMD_W       = 6;
  localparam logic [5:0]  WRITE_CMD   = 6'h25;
  localparam int          FC_LSB      = 213;
  localparam int          FC_W        = 5;
  localparam int          BC_LSB      = 192;
  localparam int          BC_W        = 21;
  localparam int          GS_W        = 16;
  localparam int          NUM_CH      = 12;
  // function control bit positions inside the five-bit field
  localparam int          FC_EXT_POS   = 3;
  localparam int          FC_TMG_POS   = 2;
  localparam int          FC_RPT_POS   = 1;
  localparam int          FC_BLANK_POS = 0;
  localparam logic [4:0]  FC_RESET     = 5'h01;

  // -------------------------------------------------------------------
  // timing
  // -------------------------------------------------------------------
  localparam int CLK_NS       = 20;
  localparam int IDLE_MIN_NS  = 666;
  localparam int IDLE_MAX_NS  = 2740000;
  localparam int IDLE_MIN_CYC = (IDLE_MIN_NS + CLK_NS - 1) / CLK_NS;
  localparam int IDLE_MAX_CYC = IDLE_MAX_NS / CLK_NS;
  localparam int IDLE_FACTOR  = 8;
  localparam int CNT_W        = 21;

  // -------------------------------------------------------------------
  // register map
  // -------------------------------------------------------------------
  localparam int          ADDR_W      = 8;
  localparam logic [7:0]  CTRL_OFS    = 8'h00;
  localparam logic [7:0]  STATUS_OFS  = 8'h04;
  localparam logic [7:0]  FCBC_OFS    = 8'h08;
  localparam logic [7:0]  LCNT_OFS    = 8'h0C;
  localparam logic [7:0]  GS_OFS      = 8'h10;
  localparam logic [7:0]  GS_END      = 8'h3C;
  localparam int          CTRL_KILL   = 0;
  localparam logic [1:0]  RESP_OKAY   = 2'h0;
  localparam logic [1:0]  RESP_SLVERR = 2'h2;

endpackage : lpl_pkg

// File: logic/lpl_link_sync.sv
// shift clock synchroniser, edge finder and latch idle detector
`timescale 1ns/100ps
module lpl_link_sync #(
  parameter int MAX_CYC = lpl_pkg::IDLE_MAX_CYC
) (
  // clock and reset
  input  wire logic aclk,
  input  wire logic aresetn,
  // pins
  input  wire logic shift_clock_in,
  input  wire logic serial_data_in,
  // to the loader
  output logic      sck_rise,
  output logic      data_bit,
  output logic      latch_pulse
);

  logic [2:0]                     sck_q;
  logic [1:0]                     sdi_q;
  logic [lpl_pkg::CNT_W-1:0]      since;
  logic [lpl_pkg::CNT_W-1:0]      period;
  logic                           armed;

  // -------------------------------------------------------------------
  // two-stage synchronisers; only stage two and later are read
  // -------------------------------------------------------------------
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      sck_q <= 3'h0;
      sdi_q <= 2'h0;
    end
    else
    begin
      sck_q <= {sck_q[1:0], shift_clock_in};
      sdi_q <= {sdi_q[0], serial_data_in};
    end
  end

  assign sck_rise = sck_q[1] & ~sck_q[2];
  assign data_bit = sdi_q[1];

  // -------------------------------------------------------------------
  // idle threshold follows the last measured period
  // -------------------------------------------------------------------
  wire [lpl_pkg::CNT_W-1:0] thr_raw = {period[lpl_pkg::CNT_W-4:0], 3'h0};
  wire [lpl_pkg::CNT_W-1:0] thr_min = lpl_pkg::CNT_W'(lpl_pkg::IDLE_MIN_CYC);
  wire [lpl_pkg::CNT_W-1:0] thr_max = lpl_pkg::CNT_W'(MAX_CYC);
  wire                      big     = period > (thr_max >> 3);
  wire [lpl_pkg::CNT_W-1:0] thr     = big ? thr_max :
                                      (thr_raw < thr_min) ? thr_min :
                                      (thr_raw > thr_max) ? thr_max :
                                      thr_raw; // R14
  wire                      sat     = since >= thr_max;
  wire                      idle    = armed & ~sck_rise & (since >= thr);

  assign latch_pulse = idle; // R6 R7

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      since  <= '1;
      period <= '1;
      armed  <= 1'b0;
    end
    else
    begin
      if (sck_rise)
      begin
        period <= since + lpl_pkg::CNT_W'(1);
        since  <= '0;
      end
      else if (!sat)
        since <= since + lpl_pkg::CNT_W'(1);
      if (sck_rise)
        armed <= 1'b1;
      else if (idle)
        armed <= 1'b0;
    end
  end

endmodule : lpl_link_sync

// File: logic/lpl_pwm_seq.sv
// grayscale pwm step counter and per-channel comparators
`timescale 1ns/100ps
module lpl_pwm_seq (
  // clock and reset
  input  wire logic        aclk,
  input  wire logic        aresetn,
  // control
  input  wire logic        step_en,
  input  wire logic        restart,
  input  wire logic        repeat_en,
  input  wire logic [191:0] gs_flat,
  // state
  output logic [11:0]      ch_on,
  output logic [15:0]      step,
  output logic             active
);

  logic armed;
  wire  running  = armed | active;
  wire  last     = step == 16'hFFFF;

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      step   <= 16'h0000;
      active <= 1'b0;
      armed  <= 1'b1;
    end
    else if (restart)
    begin
      step   <= 16'h0000; // R9
      active <= 1'b0;
      armed  <= 1'b1;
    end
    else if (step_en && running)
    begin
      step   <= step + 16'h0001; // R17
      armed  <= 1'b0;
      active <= last ? repeat_en : 1'b1; // R9 R12
    end
  end

  // -------------------------------------------------------------------
  // channel i is lit for the first gs clocks of each period
  // -------------------------------------------------------------------
  // one register process for the whole vector keeps ch_on single-driven
  wire [11:0] next_ch_on;

  genvar i;
  generate
    for (i = 0; i < lpl_pkg::NUM_CH; i = i + 1)
    begin : g_ch
      wire [15:0] gs = gs_flat[i*16 +: 16];
      assign next_ch_on[i] = step < gs; // R11
    end
  endgenerate

  always_ff @(posedge aclk)
  begin
    if (!aresetn || restart)
      ch_on <= 12'h000;
    else if (step_en && running)
      ch_on <= next_ch_on;
  end

endmodule : lpl_pwm_seq

// File: logic/lpl_loader.sv
// serial packet loader and pwm sequencer with axi4-lite status port
//
// The placing of the registers and the AXI4-Lite register port were decided locally.
`timescale 1ns/100ps
module lpl_loader #(
  parameter int P_IDLE_MAX_CYC = lpl_pkg::IDLE_MAX_CYC
) (
  // clock and reset
  input  wire logic        aclk,
  input  wire logic        aresetn,
  // serial link
  input  wire logic        shift_clock_in,
  input  wire logic        serial_data_in,
  output logic             serial_data_out,
  // led outputs
  output logic [11:0]      led_output_channel,
  // axi4-lite write address
  input  wire logic [7:0]  s_axi_awaddr,
  input  wire logic [2:0]  s_axi_awprot,
  input  wire logic        s_axi_awvalid,
  output logic             s_axi_awready,
  // axi4-lite write data
  input  wire logic [31:0] s_axi_wdata,
  input  wire logic [3:0]  s_axi_wstrb,
  input  wire logic        s_axi_wvalid,
  output logic             s_axi_wready,
  // axi4-lite write response
  output logic [1:0]       s_axi_bresp,
  output logic             s_axi_bvalid,
  input  wire logic        s_axi_bready,
  // axi4-lite read address
  input  wire logic [7:0]  s_axi_araddr,
  input  wire logic [2:0]  s_axi_arprot,
  input  wire logic        s_axi_arvalid,
  output logic             s_axi_arready,
  // axi4-lite read data
  output logic [31:0]      s_axi_rdata,
  output logic [1:0]       s_axi_rresp,
  output logic             s_axi_rvalid,
  input  wire logic        s_axi_rready
);

  // -------------------------------------------------------------------
  // link front end
  // -------------------------------------------------------------------
  logic                            sck_rise;
  logic                            data_bit;
  logic                            latch_pulse;
  logic [lpl_pkg::PKT_W-1:0]       shreg;
  logic [lpl_pkg::LATCH_W-1:0]     latch;
  logic [15:0]                     ok_cnt;
  logic [15:0]                     bad_cnt;
  logic                            kill;

  lpl_link_sync #(
    .MAX_CYC        (P_IDLE_MAX_CYC)
  ) u_sync (
    .aclk           (aclk),
    .aresetn        (aresetn),
    .shift_clock_in (shift_clock_in),
    .serial_data_in (serial_data_in),
    .sck_rise       (sck_rise),
    .data_bit       (data_bit),
    .latch_pulse    (latch_pulse)
  );

  // -------------------------------------------------------------------
  // shift register, oldest bit leaves first toward the next device
  // -------------------------------------------------------------------
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
      shreg <= '0;
    else if (sck_rise)
      shreg <= {shreg[lpl_pkg::PKT_W-2:0], data_bit}; // R3 R21
  end

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
      serial_data_out <= 1'b0;
    else
      serial_data_out <= shreg[lpl_pkg::PKT_W-1]; // R21
  end

  // -------------------------------------------------------------------
  // data latch
  // -------------------------------------------------------------------
  wire [5:0] cmd    = shreg[lpl_pkg::PKT_W-1 -: lpl_pkg::CMD_W];
  wire       cmd_ok = cmd == lpl_pkg::WRITE_CMD; // R3 R4
  wire       take   = latch_pulse & cmd_ok;

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
      latch <= {lpl_pkg::FC_RESET, {(lpl_pkg::LATCH_W-5){1'b0}}}; // R2
    else if (take)
      latch <= shreg[lpl_pkg::LATCH_W-1:0]; // R4 R7
  end

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      ok_cnt  <= 16'h0000;
      bad_cnt <= 16'h0000;
    end
    else if (latch_pulse)
    begin
      if (cmd_ok)
        ok_cnt <= ok_cnt + 16'h0001;
      else
        bad_cnt <= bad_cnt + 16'h0001;
    end
  end

  // -------------------------------------------------------------------
  // field decode
  // -------------------------------------------------------------------
  wire [4:0]   fc      = latch[lpl_pkg::FC_LSB +: lpl_pkg::FC_W]; // R19
  wire [20:0]  bc      = latch[lpl_pkg::BC_LSB +: lpl_pkg::BC_W]; // R19
  wire [191:0] gs_flat = latch[191:0]; // R19
  wire         ext_gs_clock_select = fc[lpl_pkg::FC_EXT_POS];
  wire         timing_reset_flag   = fc[lpl_pkg::FC_TMG_POS];
  wire         display_repeat_flag = fc[lpl_pkg::FC_RPT_POS];
  wire         blank               = fc[lpl_pkg::FC_BLANK_POS];
  // the reset applies with the flags of the packet just latched
  wire         new_tmg = shreg[lpl_pkg::FC_LSB + lpl_pkg::FC_TMG_POS];
  wire         restart = take & new_tmg; // R9

  // -------------------------------------------------------------------
  // pwm sequencer
  // -------------------------------------------------------------------
  logic [11:0] ch_on;
  logic [15:0] step;
  logic        active;
  wire         step_en = sck_rise & ext_gs_clock_select; // R1 R17

  lpl_pwm_seq u_pwm (
    .aclk      (aclk),
    .aresetn   (aresetn),
    .step_en   (step_en),
    .restart   (restart),
    .repeat_en (display_repeat_flag),
    .gs_flat   (gs_flat),
    .ch_on     (ch_on),
    .step      (step),
    .active    (active)
  );

  // outputs stay dark while the disable flag or the software kill is set
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
      led_output_channel <= 12'h000; // R2
    else
      led_output_channel <= (blank | kill) ? 12'h000 : ch_on; // R2 R11
  end

  // -------------------------------------------------------------------
  // axi4-lite write channel
  // -------------------------------------------------------------------
  logic        aw_held;
  logic        w_held;
  logic [7:0]  aw_addr;
  logic [31:0] w_data;
  logic [3:0]  w_strb;

  assign s_axi_awready = ~aw_held & ~s_axi_bvalid;
  assign s_axi_wready  = ~w_held & ~s_axi_bvalid;

  wire aw_fire  = s_axi_awvalid & s_axi_awready;
  wire w_fire   = s_axi_wvalid & s_axi_wready;
  wire do_write = aw_held & w_held & ~s_axi_bvalid;
  wire wr_ctrl  = aw_addr == lpl_pkg::CTRL_OFS;
  wire wr_known = wr_ctrl | (aw_addr == lpl_pkg::STATUS_OFS) |
                  (aw_addr == lpl_pkg::FCBC_OFS) |
                  (aw_addr == lpl_pkg::LCNT_OFS) |
                  ((aw_addr >= lpl_pkg::GS_OFS) &&
                   (aw_addr <= lpl_pkg::GS_END) && (aw_addr[1:0] == 2'h0));

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      aw_held      <= 1'b0;
      w_held       <= 1'b0;
      aw_addr      <= 8'h00;
      w_data       <= 32'h0000_0000;
      w_strb       <= 4'h0;
      s_axi_bvalid <= 1'b0;
      s_axi_bresp  <= lpl_pkg::RESP_OKAY;
    end
    else
    begin
      if (aw_fire)
      begin
        aw_held <= 1'b1;
        aw_addr <= s_axi_awaddr;
      end
      if (w_fire)
      begin
        w_held <= 1'b1;
        w_data <= s_axi_wdata;
        w_strb <= s_axi_wstrb;
      end
      if (do_write)
      begin
        aw_held      <= 1'b0;
        w_held       <= 1'b0;
        s_axi_bvalid <= 1'b1;
        s_axi_bresp  <= wr_known ? lpl_pkg::RESP_OKAY : lpl_pkg::RESP_SLVERR;
      end
      else if (s_axi_bready)
        s_axi_bvalid <= 1'b0;
    end
  end

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
      kill <= 1'b0;
    else if (do_write && wr_ctrl && w_strb[0])
      kill <= w_data[lpl_pkg::CTRL_KILL];
  end

  // -------------------------------------------------------------------
  // axi4-lite read channel
  // -------------------------------------------------------------------
  assign s_axi_arready = ~s_axi_rvalid;

  wire        ar_fire = s_axi_arvalid & s_axi_arready;
  wire [7:0]  ra      = s_axi_araddr;
  wire        ra_gs   = (ra >= lpl_pkg::GS_OFS) && (ra <= lpl_pkg::GS_END) &&
                        (ra[1:0] == 2'h0);
  wire [3:0]  gs_idx  = 4'(ra[5:2] - 4'h4);
  wire [15:0] gs_word = gs_flat[gs_idx*16 +: 16];
  wire [31:0] st_word = {13'h0000, ext_gs_clock_select, blank,
                         active, step};
  wire [31:0] fb_word = {6'h00, bc, fc};
  wire [31:0] rd_mux  = (ra == lpl_pkg::CTRL_OFS)   ? {31'h0, kill} :
                        (ra == lpl_pkg::STATUS_OFS) ? st_word :
                        (ra == lpl_pkg::FCBC_OFS)   ? fb_word :
                        (ra == lpl_pkg::LCNT_OFS)   ? {bad_cnt, ok_cnt} :
                        ra_gs                       ? {16'h0000, gs_word} :
                                                      32'h0000_0000;
  wire        ra_ok   = (ra == lpl_pkg::CTRL_OFS) |
                        (ra == lpl_pkg::STATUS_OFS) |
                        (ra == lpl_pkg::FCBC_OFS) |
                        (ra == lpl_pkg::LCNT_OFS) | ra_gs;

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      s_axi_rvalid <= 1'b0;
      s_axi_rdata  <= 32'h0000_0000;
      s_axi_rresp  <= lpl_pkg::RESP_OKAY;
    end
    else if (ar_fire)
    begin
      s_axi_rvalid <= 1'b1;
      s_axi_rdata  <= rd_mux;
      s_axi_rresp  <= ra_ok ? lpl_pkg::RESP_OKAY : lpl_pkg::RESP_SLVERR;
    end
    else if (s_axi_rready)
      s_axi_rvalid <= 1'b0;
  end

endmodule : lpl_loader

// File: test/lpl_loader_checker.sv
// port assertions for the packet loader
`timescale 1ns/100ps
module lpl_loader_checker #(
  parameter int P_IDLE_MAX_CYC = 2000
) (
  // clock and reset
  input wire logic        aclk,
  input wire logic        aresetn,
  // link and leds
  input wire logic        shift_clock_in,
  input wire logic        serial_data_out,
  input wire logic [11:0] led_output_channel,
  // axi4-lite
  input wire logic        s_axi_awvalid,
  input wire logic        s_axi_awready,
  input wire logic        s_axi_wvalid,
  input wire logic        s_axi_wready,
  input wire logic        s_axi_bvalid,
  input wire logic        s_axi_bready,
  input wire logic [7:0]  s_axi_araddr,
  input wire logic        s_axi_arvalid,
  input wire logic        s_axi_arready,
  input wire logic [31:0] s_axi_rdata,
  input wire logic [1:0]  s_axi_rresp,
  input wire logic        s_axi_rvalid,
  input wire logic        s_axi_rready
);
  logic       sck_prev;
  logic [7:0] sck_age;
  logic [7:0] wr_age;

  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);

  // ----------------------------------------------------------------
  // helper ages, saturating so idle gaps never wrap
  // ----------------------------------------------------------------
  always_ff @(posedge aclk)
    sck_prev <= shift_clock_in;

  always_ff @(posedge aclk)
    if (!aresetn || (shift_clock_in && !sck_prev))
      sck_age <= 8'h00;
    else if (sck_age != 8'hFF)
      sck_age <= sck_age + 8'h01;

  always_ff @(posedge aclk)
    if (!aresetn || (s_axi_awvalid && s_axi_awready))
      wr_age <= 8'h00;
    else if (wr_age != 8'hFF)
      wr_age <= wr_age + 8'h01;

  // ----------------------------------------------------------------
  // properties
  // ----------------------------------------------------------------
  property p_reset_dark;
    $rose(aresetn) |-> led_output_channel == 12'h000 && !s_axi_bvalid
      && !s_axi_rvalid;
  endproperty
  property p_led_follow;
    $changed(led_output_channel) |-> sck_age <= 8'h0C || wr_age <= 8'h03;
  endproperty
  property p_sdo_follow;
    $changed(serial_data_out) |-> sck_age <= 8'h0C;
  endproperty
  property p_b_answer;
    s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready
      |-> ##2 s_axi_bvalid;
  endproperty
  property p_b_drop;
    s_axi_bvalid && s_axi_bready |=> !s_axi_bvalid;
  endproperty
  property p_r_answer;
    s_axi_arvalid && s_axi_arready |=> s_axi_rvalid;
  endproperty
  property p_r_drop;
    s_axi_rvalid && s_axi_rready |=> !s_axi_rvalid;
  endproperty
  property p_ar_refuse;
    s_axi_rvalid |-> !s_axi_arready;
  endproperty
  property p_unmapped;
    s_axi_arvalid && s_axi_arready && s_axi_araddr > 8'h3C
      |=> s_axi_rresp == 2'h2 && s_axi_rdata == 32'h0;
  endproperty

  a_reset_dark: assert property (p_reset_dark)
    else $error("outputs not idle after reset");
  a_led_follow: assert property (p_led_follow)
    else $error("led change without shift clock or write");
  a_sdo_follow: assert property (p_sdo_follow)
    else $error("cascade output moved without shift clock");
  a_b_answer: assert property (p_b_answer)
    else $error("write response late");
  a_b_drop: assert property (p_b_drop)
    else $error("write response held after bready");
  a_r_answer: assert property (p_r_answer)
    else $error("read data late");
  a_r_drop: assert property (p_r_drop)
    else $error("read data held after rready");
  a_ar_refuse: assert property (p_ar_refuse)
    else $error("read address taken while data pending");
  a_unmapped: assert property (p_unmapped)
    else $error("unmapped read not refused");

  c_led_on: cover property (led_output_channel != 12'h000);
  c_sdo_high: cover property (serial_data_out);
  c_slverr: cover property (s_axi_rvalid && s_axi_rresp == 2'h2);
endmodule : lpl_loader_checker

// File: test/lpl_ctrl_model.sv
// external controller: shift clock and serial data source
`timescale 1ns/100ps
module lpl_ctrl_model (
  // clock
  input wire logic aclk,
  // link
  output logic     shift_clock_in,
  output logic     serial_data_in
);
  initial
  begin
    shift_clock_in = 1'b0;
    serial_data_in = 1'b1;
  end

  // one 160 ns period per bit, data settled two cycles before the rise
  task automatic bits(input logic [223:0] p, input int n);
    for (int i = n - 1; i >= 0; i--)
    begin
      @(posedge aclk);
      serial_data_in <= p[i];
      repeat (2) @(posedge aclk);
      shift_clock_in <= 1'b1;
      repeat (4) @(posedge aclk);
      shift_clock_in <= 1'b0;
      @(posedge aclk);
    end
    // data no longer meaningful between frames
    serial_data_in <= ~serial_data_in;
  endtask : bits

  // clock held still: latch interval, then the start gap
  task automatic idle(input int c);
    repeat (c) @(posedge aclk);
  endtask : idle
endmodule : lpl_ctrl_model

// File: test/tb_lpl_loader.sv
// testbench for the packet loader and pwm sequencer
`timescale 1ns/100ps
module tb_lpl_loader;
  typedef struct packed
  {
    logic [7:0]  a;
    logic [31:0] d;
    logic [1:0]  r;
  } lpl_row_t;

  logic        aclk;
  logic        aresetn;
  wire logic   shift_clock_in;
  wire logic   serial_data_in;
  logic        serial_data_out;
  logic [11:0] led_output_channel;
  logic [7:0]  s_axi_awaddr;
  logic        s_axi_awvalid;
  logic        s_axi_awready;
  logic [31:0] s_axi_wdata;
  logic [3:0]  s_axi_wstrb;
  logic        s_axi_wvalid;
  logic        s_axi_wready;
  logic [1:0]  s_axi_bresp;
  logic        s_axi_bvalid;
  logic        s_axi_bready;
  logic [7:0]  s_axi_araddr;
  logic        s_axi_arvalid;
  logic        s_axi_arready;
  logic [31:0] s_axi_rdata;
  logic [1:0]  s_axi_rresp;
  logic        s_axi_rvalid;
  logic        s_axi_rready;
  logic [31:0] rd;
  logic [1:0]  rs;
  int          mismatches;
  int          tests_run;
  int          cycles;
  lpl_row_t    rows [6] = '{'{8'h08, 32'hC, 2'h0}, '{8'h0C, 32'h1, 2'h0},
    '{8'h10, 32'h0, 2'h0}, '{8'h14, 32'h3, 2'h0},
    '{8'h3C, 32'h21, 2'h0}, '{8'h40, 32'h0, 2'h2}};

  lpl_loader #(.P_IDLE_MAX_CYC(2000)) u_lpl_loader (.*,
    .s_axi_awprot(3'h0), .s_axi_arprot(3'h0));
  lpl_ctrl_model u_lpl_ctrl_model (.aclk(aclk),
    .shift_clock_in(shift_clock_in), .serial_data_in(serial_data_in));

  function automatic logic [223:0] pkt(input logic [5:0] c,
                                       input logic [15:0] b);
    logic [223:0] p;
    p = {c, 5'h0C, 21'h0, 192'h0};
    for (int i = 0; i < 12; i++)
      p[16*i +: 16] = b + 16'(3 * i);
    return p;
  endfunction : pkt

  // channel i holds 3*i; k never equals 3*i, so the edge is unambiguous
  function automatic logic [31:0] lit(input int k);
    lit = 32'h0;
    for (int i = 0; i < 12; i++)
      lit[i] = (3 * i > k);
  endfunction : lit

  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    tests_run++;
    if (seen !== exp)
    begin
      mismatches++;
      $display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask : check

  task automatic axi_write(input logic [7:0] a, input logic [31:0] d,
                           output logic [1:0] r);
    @(posedge aclk);
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    do
    begin
      @(posedge aclk);
      if (s_axi_awready)
        s_axi_awvalid <= 1'b0;
      if (s_axi_wready)
        s_axi_wvalid <= 1'b0;
    end while (!s_axi_bvalid);
    r = s_axi_bresp;
    s_axi_bready <= 1'b0;
  endtask : axi_write

  task automatic axi_read(input logic [7:0] a, output logic [31:0] d,
                          output logic [1:0] r);
    @(posedge aclk);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    do
    begin
      @(posedge aclk);
      if (s_axi_arready)
        s_axi_arvalid <= 1'b0;
    end while (!s_axi_rvalid);
    d = s_axi_rdata;
    r = s_axi_rresp;
    s_axi_rready <= 1'b0;
  endtask : axi_read

  task automatic close_out();
    $display("comparisons %0d, mismatches %0d", tests_run, mismatches);
    if (mismatches == 0 && tests_run > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask : close_out

  initial
  begin
    aclk = 1'b0;
    forever #10 aclk = ~aclk;
  end

  always @(posedge aclk)
  begin
    cycles++;
    if (cycles == 20000)
    begin
      mismatches++;
      close_out();
    end
  end

  initial
  begin
    {aresetn, s_axi_awvalid, s_axi_wvalid, s_axi_bready} = 4'h0;
    {s_axi_arvalid, s_axi_rready, s_axi_awaddr, s_axi_araddr} = 18'h0;
    s_axi_wdata = 32'h0;
    s_axi_wstrb = 4'hF;
    repeat (5) @(posedge aclk);
    aresetn <= 1'b1;
    @(posedge aclk);
    check(32'(led_output_channel), 32'h0);
    axi_read(8'h04, rd, rs);
    check(32'(rd[18:17]), 32'h1);
    u_lpl_ctrl_model.bits(pkt(6'h25, 16'h0), 224);
    u_lpl_ctrl_model.idle(160);
    foreach (rows[i])
    begin
      axi_read(rows[i].a, rd, rs);
      check(rd, rows[i].d);
      check(32'(rs), 32'(rows[i].r));
    end
    axi_read(8'h04, rd, rs);
    check(32'(rd[18:17]), 32'h2);
    u_lpl_ctrl_model.bits(224'h0, 1);
    repeat (8) @(posedge aclk);
    check(32'(led_output_channel), lit(1));
    u_lpl_ctrl_model.bits(224'h0, 9);
    repeat (8) @(posedge aclk);
    check(32'(led_output_channel), lit(10));
    axi_write(8'h00, 32'h1, rs);
    @(posedge aclk);
    check(32'(led_output_channel), 32'h0);
    axi_write(8'h00, 32'h0, rs);
    @(posedge aclk);
    check(32'(led_output_channel), lit(10));
    axi_write(8'h04, 32'hFFFFFFFF, rs);
    check(32'(rs), 32'h0);
    axi_write(8'h44, 32'h1, rs);
    check(32'(rs), 32'h2);
    u_lpl_ctrl_model.bits(pkt(6'h35, 16'h0100), 224);
    repeat (8) @(posedge aclk);
    check(32'(serial_data_out), 32'h1);
    check(32'(led_output_channel), 32'h0);
    u_lpl_ctrl_model.idle(160);
    axi_read(8'h04, rd, rs);
    check(rd, 32'h0005_00EA);
    axi_read(8'h14, rd, rs);
    check(rd, 32'h3);
    axi_read(8'h0C, rd, rs);
    check(rd, 32'h00010001);
    aresetn <= 1'b0;
    repeat (5) @(posedge aclk);
    aresetn <= 1'b1;
    @(posedge aclk);
    check(32'(led_output_channel), 32'h0);
    axi_read(8'h04, rd, rs);
    check(32'(rd[18:17]), 32'h1);
    close_out();
  end
endmodule : tb_lpl_loader

bind lpl_loader lpl_loader_checker #(.P_IDLE_MAX_CYC(P_IDLE_MAX_CYC))
  u_lpl_loader_checker (.aclk(aclk), .aresetn(aresetn),
  .shift_clock_in(shift_clock_in), .serial_data_out(serial_data_out),
  .led_output_channel(led_output_channel),
  .s_axi_awvalid(s_axi_awvalid), .s_axi_awready(s_axi_awready),
  .s_axi_wvalid(s_axi_wvalid), .s_axi_wready(s_axi_wready),
  .s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready),
  .s_axi_araddr(s_axi_araddr), .s_axi_arvalid(s_axi_arvalid),
  .s_axi_arready(s_axi_arready), .s_axi_rdata(s_axi_rdata),
  .s_axi_rresp(s_axi_rresp), .s_axi_rvalid(s_axi_rvalid),
  .s_axi_rready(s_axi_rready));
